// ===== flashover_pkg.sv
// Constants shared by the breaker flashover detector: register map, field positions,
// reset values and timing counts. Assumes a 25 MHz core clock.
// Functional notes
// - With two sets a phase arms on difference above its pickup, some voltage above pickup and no current.
// - With two sets an armed phase picks up and starts its timer when both sides and the difference drop and current flows.
// - The operate output rises only after pickup has persisted for the programmed delay.
// - Each phase is blocked by its own supervision input and for six power-system cycles after it falls.
// - With two voltage sets no breaker status is needed to arm; the open status is an optional extra condition.
// - Each pole has its own breaker-open status input qualifying its own phase.
// - With two voltage sets live voltage on either side, or both, arms the element.
// - The element works only with phase-to-ground voltages and never operates when delta inputs are configured.
// - Voltages and currents come from the first side; the second side supplies voltages only.
// - The difference pickup is in primary volts, the same scale as the difference of the two sides.
// - Without a second side a phase arms on live voltage, open status and no current, ignoring the difference.
// - Detection resets when current returns to zero, the breaker closes while its status is used, or supervision goes high.
package flashover_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 3;
    localparam int PHASES = 3;

    // Register offsets (word index)
    localparam logic [ADDR_W-1:0] CTRL_OFS = 3'h0;
    localparam logic [ADDR_W-1:0] VPKP_OFS = 3'h1;
    localparam logic [ADDR_W-1:0] DPKP_OFS = 3'h2;
    localparam logic [ADDR_W-1:0] IPKP_OFS = 3'h3;
    localparam logic [ADDR_W-1:0] DELAY_OFS = 3'h4;
    localparam logic [ADDR_W-1:0] STATE_OFS = 3'h5;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 3'h6;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 3'h7;

    // Control field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_SIDE2_BIT = 1;
    localparam int CTRL_USE_STATUS_BIT = 2;
    localparam int CTRL_DELTA_BIT = 3;

    // State/interrupt field positions (three bits per group)
    localparam int ARMED_LSB = 0;
    localparam int PICKUP_LSB = 3;
    localparam int OPERATE_LSB = 6;
    localparam int BLOCKED_LSB = 9;

    // Reset values
    localparam logic [DATA_W-1:0] CTRL_RST = 16'h0000;
    localparam logic [DATA_W-1:0] VPKP_RST = 16'h0000;
    localparam logic [DATA_W-1:0] DPKP_RST = 16'h0000;
    localparam logic [DATA_W-1:0] IPKP_RST = 16'h0000;
    localparam logic [DATA_W-1:0] DELAY_RST = 16'h0000;
    localparam logic [DATA_W-1:0] MASK_RST = 16'h0000;

    // Timing
    localparam int CLK_KHZ = 25000;
    localparam int TICK_TIME_US = 1000;
    localparam int TICK_CYCLES = (TICK_TIME_US * CLK_KHZ) / 1000;
    localparam int POWER_CYCLE_MS = 20;
    localparam int SUPV_HOLD_POWER_CYCLES = 6;
    localparam int SUPV_HOLD_TICKS = SUPV_HOLD_POWER_CYCLES * POWER_CYCLE_MS;
    localparam int HOLD_W = 8;
endpackage

// ===== tick_divider.sv
// Millisecond timebase: one-cycle pulse every TICK_CYCLES clocks.
// Assumes a free-running core clock.
`timescale 1ns/1ps
module tick_divider #(
    parameter int TICK_CYCLES = flashover_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Timebase
    output logic tick
);
    logic [31:0] count_q;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            count_q <= 32'h0000_0000;
            tick <= 1'b0;
        end else if (count_q >= 32'(TICK_CYCLES - 1)) begin
            count_q <= 32'h0000_0000;
            tick <= 1'b1;
        end else begin
            count_q <= count_q + 32'h0000_0001;
            tick <= 1'b0;
        end
    end
endmodule // tick_divider

// ===== supervision_hold.sv
// Per-phase supervision: blocks while the supervision input is high and for a fixed
// number of timebase ticks after it falls. Input is from logic on the same clock.
`timescale 1ns/1ps
module supervision_hold (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Timebase and supervision
    input wire logic tick,
    input wire logic supervise,
    // Result
    output logic blocked
);
    logic [flashover_pkg::HOLD_W-1:0] hold_q;

    // Stretched so a trip that just ended cannot let the element pick up on the tail
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hold_q <= '0;
        end else if (supervise) begin
            hold_q <= flashover_pkg::HOLD_W'(flashover_pkg::SUPV_HOLD_TICKS);
        end else if (tick && hold_q != '0) begin
            hold_q <= hold_q - 1'b1;
        end
    end

    assign blocked = supervise || (hold_q != '0);
endmodule // supervision_hold

// ===== breaker_flashover_detector.sv
// Breaker flashover detector: three phase machines sharing one live-voltage test, a settable operate
// delay, supervision hold, a small register file and a level interrupt.
// Measurements are magnitudes in primary units from logic on the same clock.
`timescale 1ns/1ps
module breaker_flashover_detector #(
    parameter int TICK_CYCLES = flashover_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // First side: phase voltages and currents, A in [15:0]
    input wire logic [3*flashover_pkg::DATA_W-1:0] side1_voltage,
    input wire logic [3*flashover_pkg::DATA_W-1:0] side1_current,
    // Second side: phase voltages only
    input wire logic [3*flashover_pkg::DATA_W-1:0] side2_voltage,
    // Per-pole status and supervision, bit 0 is phase A
    input wire logic [2:0] pole_open_status_input,
    input wire logic [2:0] per_phase_supervision_input,
    // Register port
    input wire logic [flashover_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [flashover_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [flashover_pkg::DATA_W-1:0] reg_rdata,
    // Results
    output logic [2:0] phase_pickup,
    output logic [2:0] phase_operate,
    output logic pickup,
    output logic operate,
    output logic irq
);
    localparam int W = flashover_pkg::DATA_W;

    typedef enum logic [1:0] {
        idle,
        armed,
        picked,
        operated
    } phase_state_type;

    logic [W-1:0] ctrl_q;
    logic [W-1:0] vpkp_q;
    logic [W-1:0] dpkp_q;
    logic [W-1:0] ipkp_q;
    logic [W-1:0] delay_q;
    logic [W-1:0] irq_stat_q;
    logic [W-1:0] irq_mask_q;
    logic [W-1:0] rdata_q;
    logic [2:0] armed_flag;
    logic [2:0] blocked;
    logic [2:0] live;
    logic [2:0] pickup_prev_q;
    logic [2:0] operate_prev_q;
    logic live_any;
    logic tick;
    logic enable;
    logic two_sets;
    logic use_status;
    logic wye_ok;

    function automatic logic [W-1:0] phase_word(input logic [3*W-1:0] bus, input int idx);
        phase_word = bus[idx*W +: W];
    endfunction

    function automatic logic reg_hit(input logic [flashover_pkg::ADDR_W-1:0] a,
                                     input logic [flashover_pkg::ADDR_W-1:0] ofs);
        reg_hit = (a == ofs);
    endfunction

    assign enable = ctrl_q[flashover_pkg::CTRL_ENABLE_BIT];
    assign two_sets = ctrl_q[flashover_pkg::CTRL_SIDE2_BIT];
    assign use_status = ctrl_q[flashover_pkg::CTRL_USE_STATUS_BIT];
    assign wye_ok = !ctrl_q[flashover_pkg::CTRL_DELTA_BIT];

    tick_divider #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .tick(tick)
    );

    // Live voltage on side one, or on either side with two sets, of any phase readies every phase
    assign live_any = |live;

    generate
        for (genvar p = 0; p < 3; p++) begin : g_phase
            phase_state_type state_q;
            logic [W-1:0] v1;
            logic [W-1:0] v2;
            logic [W-1:0] cur;
            logic [W-1:0] diff;
            logic [W-1:0] timer_q;
            logic no_current;
            logic has_current;
            logic pole_open;
            logic arm_ok;
            logic collapse_ok;
            logic reset_cond;

            assign v1 = phase_word(side1_voltage, p);
            assign v2 = phase_word(side2_voltage, p);
            assign cur = phase_word(side1_current, p);
            // Difference in primary volts, compared against a primary-volt setting
            assign diff = (v1 >= v2) ? (v1 - v2) : (v2 - v1);
            assign live[p] = (v1 > vpkp_q) || (two_sets && (v2 > vpkp_q));
            assign no_current = !(cur > ipkp_q);
            assign has_current = cur > ipkp_q;
            assign pole_open = pole_open_status_input[p];

            // Status is mandatory with one set, optional with two
            always_comb begin
                if (two_sets) begin
                    arm_ok = (diff > dpkp_q) && live_any && no_current
                        && (!use_status || pole_open);
                end else begin
                    arm_ok = live_any && pole_open && no_current;
                end
            end

            always_comb begin
                if (two_sets) begin
                    collapse_ok = (v1 < vpkp_q) && (v2 < vpkp_q) && (diff < dpkp_q)
                        && has_current && (!use_status || pole_open);
                end else begin
                    collapse_ok = (v1 < vpkp_q) && has_current && pole_open;
                end
            end

            // Current gone, breaker closed while status is used, or supervised: start over
            assign reset_cond = !enable || blocked[p] || !wye_ok
                || ((use_status || !two_sets) && !pole_open);

            supervision_hold u_supv (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .tick(tick),
                .supervise(per_phase_supervision_input[p]),
                .blocked(blocked[p])
            );

            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    state_q <= idle;
                end else if (reset_cond) begin
                    state_q <= idle;
                end else begin
                    unique case (state_q)
                        idle: begin
                            if (arm_ok) begin
                                state_q <= armed;
                            end
                        end
                        armed: begin
                            if (collapse_ok) begin
                                state_q <= picked;
                            end
                        end
                        picked: begin
                            if (no_current) begin
                                state_q <= idle;
                            end else if (timer_q >= delay_q) begin
                                state_q <= operated;
                            end
                        end
                        operated: begin
                            if (no_current) begin
                                state_q <= idle;
                            end
                        end
                    endcase
                end
            end

            // Delay counted in millisecond ticks; restarts at every new pickup
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    timer_q <= '0;
                end else if (state_q != picked) begin
                    timer_q <= '0;
                end else if (tick && timer_q != '1) begin
                    timer_q <= timer_q + 1'b1;
                end
            end

            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    armed_flag[p] <= 1'b0;
                    phase_pickup[p] <= 1'b0;
                    phase_operate[p] <= 1'b0;
                end else begin
                    armed_flag[p] <= (state_q == armed);
                    phase_pickup[p] <= (state_q == picked) || (state_q == operated);
                    phase_operate[p] <= (state_q == operated) && wye_ok;
                end
            end
        end
    endgenerate

    // Summary outputs across the three phases
    assign pickup = |phase_pickup;
    assign operate = |phase_operate;

    // Configuration registers
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= flashover_pkg::CTRL_RST;
            vpkp_q <= flashover_pkg::VPKP_RST;
            dpkp_q <= flashover_pkg::DPKP_RST;
            ipkp_q <= flashover_pkg::IPKP_RST;
            delay_q <= flashover_pkg::DELAY_RST;
            irq_mask_q <= flashover_pkg::MASK_RST;
        end else if (reg_write) begin
            if (reg_hit(reg_addr, flashover_pkg::CTRL_OFS)) begin
                ctrl_q <= reg_wdata & 16'h000f;
            end
            if (reg_hit(reg_addr, flashover_pkg::VPKP_OFS)) begin
                vpkp_q <= reg_wdata; // Range not checked
            end
            if (reg_hit(reg_addr, flashover_pkg::DPKP_OFS)) begin
                dpkp_q <= reg_wdata;
            end
            if (reg_hit(reg_addr, flashover_pkg::IPKP_OFS)) begin
                ipkp_q <= reg_wdata;
            end
            if (reg_hit(reg_addr, flashover_pkg::DELAY_OFS)) begin
                delay_q <= reg_wdata;
            end
            if (reg_hit(reg_addr, flashover_pkg::IRQ_MASK_OFS)) begin
                irq_mask_q <= reg_wdata & 16'h01f8;
            end
        end
    end

    // Edge history for interrupt events
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pickup_prev_q <= 3'h0;
            operate_prev_q <= 3'h0;
        end else begin
            pickup_prev_q <= phase_pickup;
            operate_prev_q <= phase_operate;
        end
    end

    logic [W-1:0] set_bits;
    logic [W-1:0] clr_bits;

    always_comb begin
        set_bits = 16'h0000;
        set_bits[flashover_pkg::PICKUP_LSB +: 3] = phase_pickup & ~pickup_prev_q;
        set_bits[flashover_pkg::OPERATE_LSB +: 3] = phase_operate & ~operate_prev_q;
        clr_bits = (reg_write && reg_hit(reg_addr, flashover_pkg::IRQ_STAT_OFS)) ? reg_wdata : 16'h0000;
    end

    // Sticky status, write one to clear; a new event in the clear cycle survives
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            irq_stat_q <= 16'h0000;
        end else begin
            irq_stat_q <= (irq_stat_q & ~clr_bits) | set_bits;
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // Read data stands for the one cycle after the strobe; zero otherwise
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 16'h0000;
        end else if (reg_read) begin
            unique case (reg_addr)
                flashover_pkg::CTRL_OFS: rdata_q <= ctrl_q;
                flashover_pkg::VPKP_OFS: rdata_q <= vpkp_q;
                flashover_pkg::DPKP_OFS: rdata_q <= dpkp_q;
                flashover_pkg::IPKP_OFS: rdata_q <= ipkp_q;
                flashover_pkg::DELAY_OFS: rdata_q <= delay_q;
                flashover_pkg::STATE_OFS: rdata_q <= {4'h0, blocked, phase_operate, phase_pickup, armed_flag};
                flashover_pkg::IRQ_STAT_OFS: rdata_q <= irq_stat_q;
                flashover_pkg::IRQ_MASK_OFS: rdata_q <= irq_mask_q;
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign reg_rdata = rdata_q;
endmodule // breaker_flashover_detector

// ===== breaker_flashover_detector_checker.sv
// Port-level assertions for the breaker flashover detector.
// Assumes one clock domain and the asynchronous active-low reset of the top module.
`timescale 1ns/1ps
module breaker_flashover_detector_checker #(
    parameter int TICK_CYCLES = flashover_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Measurements and contacts
    input wire logic [3*flashover_pkg::DATA_W-1:0] side1_voltage,
    input wire logic [3*flashover_pkg::DATA_W-1:0] side1_current,
    input wire logic [3*flashover_pkg::DATA_W-1:0] side2_voltage,
    input wire logic [2:0] pole_open_status_input,
    input wire logic [2:0] per_phase_supervision_input,
    // Register port
    input wire logic [flashover_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [flashover_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [flashover_pkg::DATA_W-1:0] reg_rdata,
    // Results
    input wire logic [2:0] phase_pickup,
    input wire logic [2:0] phase_operate,
    input wire logic pickup,
    input wire logic operate,
    input wire logic irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_pickup_summary: assert property (pickup == (|phase_pickup))
        else $error("pickup summary differs from phase pickups");
    a_operate_summary: assert property (operate == (|phase_operate))
        else $error("operate summary differs from phase operates");
    a_operate_with_pickup: assert property ((phase_operate & ~phase_pickup) == 3'h0)
        else $error("operate without pickup on some phase");
    a_operate_after_pickup: assert property (
        (phase_operate & ~$past(phase_operate) & ~$past(phase_pickup)) == 3'h0)
        else $error("operate rose without pickup one cycle before");
    // State and output registers add two flops, so three cycles of supervision are allowed to take effect
    a_supv_blocks: assert property (
        per_phase_supervision_input[0] [*3] |=> !phase_pickup[0] && !phase_operate[0])
        else $error("phase A active while supervised");
    a_no_current_release: assert property (side1_current[15:0] == 16'h0000 [*3] |=> !phase_pickup[0])
        else $error("phase A pickup held with zero current");
    a_pickup_needs_current: assert property (
        $rose(phase_pickup[0]) |-> ($past(side1_current[15:0], 2) != 16'h0000))
        else $error("phase A pickup without current");
    a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside read answer");

    c_pickup: cover property ($rose(pickup));
    c_operate: cover property ($rose(operate));
    c_irq: cover property ($rose(irq));
    c_supervised: cover property (per_phase_supervision_input[0] && phase_operate[0]);
endmodule // breaker_flashover_detector_checker

bind breaker_flashover_detector breaker_flashover_detector_checker #(.TICK_CYCLES(TICK_CYCLES)) i_checker (
    .ref_clk(ref_clk), .resetn(resetn), .side1_voltage(side1_voltage), .side1_current(side1_current),
    .side2_voltage(side2_voltage), .pole_open_status_input(pole_open_status_input),
    .per_phase_supervision_input(per_phase_supervision_input), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .phase_pickup(phase_pickup),
    .phase_operate(phase_operate), .pickup(pickup), .operate(operate), .irq(irq));

// ===== flashover_source_model.sv
// Behavioural source of breaker measurements and pole contacts.
// Assumes the bench selects a scenario code on the detector's clock.
`timescale 1ns/1ps
module flashover_source_model (
    // Clock and scenario
    input wire logic ref_clk,
    input wire logic [2:0] mode,
    input wire logic [2:0] phase_sel,
    input wire logic aux_wired,
    // Measurements and contacts
    output logic [3*flashover_pkg::DATA_W-1:0] side1_voltage,
    output logic [3*flashover_pkg::DATA_W-1:0] side1_current,
    output logic [3*flashover_pkg::DATA_W-1:0] side2_voltage,
    output logic [2:0] pole_open_status_input
);
    // Modes: 0 dead, 1 one side live, 2 both live, 3 flashover, 4 closed on load
    logic [15:0] v1, v2, cur;
    always_comb begin
        case (mode)
            3'd0: {v1, v2, cur} = {16'h0000, 16'h0000, 16'h0000};
            3'd1: {v1, v2, cur} = {16'h03e8, 16'h0000, 16'h0000};
            3'd2: {v1, v2, cur} = {16'h03e8, 16'h05dc, 16'h0000};
            3'd3: {v1, v2, cur} = {16'h0064, 16'h0064, 16'h01f4};
            default: {v1, v2, cur} = {16'h03e8, 16'h03e8, 16'h012c};
        endcase
    end
    // Phases not selected stay closed on load
    always_ff @(posedge ref_clk) begin
        for (int p = 0; p < 3; p++) begin
            side1_voltage[16*p +: 16] <= phase_sel[p] ? v1 : 16'h03e8;
            side2_voltage[16*p +: 16] <= phase_sel[p] ? v2 : 16'h03e8;
            side1_current[16*p +: 16] <= phase_sel[p] ? cur : 16'h012c;
            // An unwired contact reads as not open
            pole_open_status_input[p] <= phase_sel[p] && aux_wired && (mode != 3'd4);
        end
    end
endmodule // flashover_source_model

// ===== test_breaker_flashover_detector.sv
// Self-checking bench: table of arming cases, then reset, operate delay with interrupt, supervision hold.
// Assumes the behavioural source model and a shortened millisecond tick.
`timescale 1ns/1ps
module test_breaker_flashover_detector;
    localparam int TICKS = 4;
    typedef struct packed {
        logic [15:0] ctrl;
        logic [2:0] arm;
        logic [2:0] sel;
        logic aux;
        logic [2:0] want;
    } row_type;
    logic ref_clk, resetn, aux_wired, reg_write, reg_read, pickup, operate, irq;
    logic [2:0] mode, phase_sel, supv, phase_pickup, phase_operate, pole_open;
    logic [3*flashover_pkg::DATA_W-1:0] v1, i1, v2;
    logic [flashover_pkg::ADDR_W-1:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rd;
    int bad_count, n_checks, n;
    row_type rows [10];

    flashover_source_model i_src (.ref_clk(ref_clk), .mode(mode), .phase_sel(phase_sel), .aux_wired(aux_wired),
        .side1_voltage(v1), .side1_current(i1), .side2_voltage(v2), .pole_open_status_input(pole_open));
    breaker_flashover_detector #(.TICK_CYCLES(TICKS)) i_dut (.ref_clk(ref_clk), .resetn(resetn),
        .side1_voltage(v1), .side1_current(i1), .side2_voltage(v2), .pole_open_status_input(pole_open),
        .per_phase_supervision_input(supv), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .phase_pickup(phase_pickup), .phase_operate(phase_operate),
        .pickup(pickup), .operate(operate), .irq(irq));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
        n_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic results();
        $display("Checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge ref_clk);
        reg_write <= 1'b0;
        #1;
    endtask

    task automatic reg_rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge ref_clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic load_settings(input logic [15:0] ctrl);
        reg_wr(flashover_pkg::VPKP_OFS, 16'h0370);
        reg_wr(flashover_pkg::DPKP_OFS, 16'h00c8);
        reg_wr(flashover_pkg::IPKP_OFS, 16'h0032);
        reg_wr(flashover_pkg::DELAY_OFS, 16'h0005);
        reg_wr(flashover_pkg::CTRL_OFS, ctrl);
    endtask

    task automatic set_mode(input logic [2:0] m, input logic [2:0] s, input logic a);
        @(posedge ref_clk);
        mode <= m;
        phase_sel <= s;
        aux_wired <= a;
        repeat (6) @(posedge ref_clk);
        #1;
    endtask

    task automatic wait_bit(input int which, output int cycles);
        cycles = 0;
        while ((which == 0 ? phase_pickup[0] : phase_operate[0]) !== 1'b1) begin
            @(posedge ref_clk);
            #1;
            cycles++;
            if (cycles > 2000) begin
                bad_count++;
                $display("FAIL wait on bit %0d expected 1 seen 0", which);
                results();
            end
        end
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    initial begin
        #400000;
        bad_count++;
        $display("FAIL run length expected finish seen hang");
        results();
    end

    initial begin
        rows = '{'{16'h0003, 3'd1, 3'b001, 1'b0, 3'b001}, '{16'h0003, 3'd2, 3'b010, 1'b0, 3'b010},
                 '{16'h0001, 3'd1, 3'b100, 1'b1, 3'b100}, '{16'h0001, 3'd1, 3'b100, 1'b0, 3'b000},
                 '{16'h0007, 3'd1, 3'b001, 1'b0, 3'b000}, '{16'h0007, 3'd1, 3'b001, 1'b1, 3'b001},
                 '{16'h000b, 3'd1, 3'b001, 1'b1, 3'b000}, '{16'h0003, 3'd1, 3'b101, 1'b0, 3'b101},
                 '{16'h0002, 3'd1, 3'b001, 1'b0, 3'b000}, '{16'h0003, 3'd0, 3'b001, 1'b1, 3'b000}};
        resetn = 1'b0;
        mode = 3'd4;
        phase_sel = 3'b000;
        aux_wired = 1'b0;
        supv = 3'b000;
        reg_addr = 3'h0;
        reg_wdata = 16'h0000;
        reg_write = 1'b0;
        reg_read = 1'b0;
        bad_count = 0;
        n_checks = 0;
        repeat (12) @(posedge ref_clk);
        resetn <= 1'b1;
        foreach (rows[k]) begin
            load_settings(rows[k].ctrl);
            set_mode(rows[k].arm, rows[k].sel, rows[k].aux);
            set_mode(3'd3, rows[k].sel, rows[k].aux);
            check("phase_pickup", 16'(phase_pickup), 16'(rows[k].want));
            set_mode(3'd0, rows[k].sel, rows[k].aux);
            check("pickup after current stops", 16'(phase_pickup), 16'h0000);
            set_mode(3'd4, 3'b000, 1'b0);
        end
        // Second reset in mid-run, then every register back to zero
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (12) @(posedge ref_clk);
        #1 check("outputs in reset", 16'({pickup, operate, irq, phase_pickup, phase_operate}), 16'h0000);
        @(posedge ref_clk);
        resetn <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            reg_rd(a[2:0], rd);
            check("register reset", rd, 16'h0000);
        end
        reg_wr(flashover_pkg::STATE_OFS, 16'hffff);
        reg_rd(flashover_pkg::STATE_OFS, rd);
        check("state write ignored", rd, 16'h0000);
        // Operate delay of 5 ms at TICKS clocks per ms, then the interrupt path
        load_settings(16'h0003);
        set_mode(3'd1, 3'b001, 1'b0);
        reg_rd(flashover_pkg::STATE_OFS, rd);
        check("state when armed", rd, 16'h0001);
        @(posedge ref_clk);
        mode <= 3'd3;
        wait_bit(0, n);
        wait_bit(1, n);
        check("operate delay in window", 16'(n >= 4*TICKS && n <= 5*TICKS + 2), 16'h0001);
        check("irq while masked", 16'(irq), 16'h0000);
        reg_wr(flashover_pkg::IRQ_MASK_OFS, 16'h01f8);
        check("irq when unmasked", 16'(irq), 16'h0001);
        reg_rd(flashover_pkg::IRQ_STAT_OFS, rd);
        check("event status", rd, 16'h0048);
        reg_wr(flashover_pkg::IRQ_STAT_OFS, 16'h0048);
        check("irq after clear", 16'(irq), 16'h0000);
        // Supervision drops an operated phase and keeps it idle for the hold time
        @(posedge ref_clk);
        supv <= 3'b001;
        repeat (4) @(posedge ref_clk);
        #1 check("supervised outputs", 16'({phase_pickup, phase_operate}), 16'h0000);
        reg_rd(flashover_pkg::STATE_OFS, rd);
        check("state while supervised", rd, 16'h0200);
        @(posedge ref_clk);
        supv <= 3'b000;
        set_mode(3'd1, 3'b001, 1'b0);
        set_mode(3'd3, 3'b001, 1'b0);
        check("pickup inside hold", 16'(phase_pickup), 16'h0000);
        set_mode(3'd0, 3'b001, 1'b0);
        repeat (500) @(posedge ref_clk);
        set_mode(3'd1, 3'b001, 1'b0);
        set_mode(3'd3, 3'b001, 1'b0);
        check("pickup after hold", 16'(phase_pickup), 16'h0001);
        results();
    end
endmodule // test_breaker_flashover_detector
